// ### hw/prlk_top.sv
// peripheral register lock: guard bank, key tracker and write gate
// assumes peripheral accesses are one-cycle strobes; gated copies leave one cycle later
`timescale 1ns/1ps
module prlk_top import prlk_pkg::*; (
	input wire logic mclk, // bus clock
	input wire logic rstn, // async reset, active low
	input wire logic key_wr, // key register write strobe
	input wire logic [PRLK_KEY_W-1:0] key_wdata, // key write data
	input wire logic guard_wr, // guard bank write strobe
	input wire logic [PRLK_NGRP-1:0] guard_wdata, // new guard bits
	input wire logic per_wr, // peripheral write request
	input wire logic per_rd, // peripheral read request
	input wire logic [PRLK_ADDR_W-1:0] per_addr, // peripheral address
	input wire logic [PRLK_DATA_W-1:0] per_wdata, // peripheral write data
	output logic key_open_reg, // key status: 1 = guard bank unlocked
	output logic [PRLK_NGRP-1:0] peripheral_group_write_guard_reg, // guard bits, 1 = group locked
	output logic per_wr_out_reg, // gated write strobe to peripherals
	output logic per_rd_out_reg, // read strobe to peripherals
	output logic [PRLK_ADDR_W-1:0] per_addr_out_reg, // address to peripherals
	output logic [PRLK_DATA_W-1:0] per_wdata_out_reg, // write data to peripherals
	output logic per_wr_drop_reg // pulse: a write was discarded
);
	logic [PRLK_NGRP-1:0] guard_next;
	logic wr_next;
	logic rd_next;
	logic drop_next;
	logic [PRLK_ADDR_W-1:0] addr_next;
	logic [PRLK_DATA_W-1:0] wdata_next;

	prlk_key_seq u_key_seq (
		.mclk(mclk),
		.rstn(rstn),
		.key_wr(key_wr),
		.key_wdata(key_wdata),
		.open_reg(key_open_reg)
	);

	// guard bank
	always_comb begin
		guard_next = peripheral_group_write_guard_reg;
		// status is registered, so the write sees the state before this cycle's key write
		if (guard_wr && key_open_reg) begin
			guard_next = guard_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			peripheral_group_write_guard_reg <= PRLK_GUARD_RST;
		end else begin
			peripheral_group_write_guard_reg <= guard_next;
		end
	end

	// access gate
	always_comb begin
		rd_next = per_rd;
		wr_next = per_wr && !prlk_is_guarded(peripheral_group_write_guard_reg, per_addr);
		drop_next = per_wr && prlk_is_guarded(peripheral_group_write_guard_reg, per_addr);
		addr_next = per_addr;
		// data is held when a write is dropped so nothing leaks to a locked group
		wdata_next = wr_next ? per_wdata : per_wdata_out_reg;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			per_wr_out_reg <= 1'b0;
			per_rd_out_reg <= 1'b0;
			per_wr_drop_reg <= 1'b0;
			per_addr_out_reg <= '0;
			per_wdata_out_reg <= '0;
		end else begin
			per_wr_out_reg <= wr_next;
			per_rd_out_reg <= rd_next;
			per_wr_drop_reg <= drop_next;
			per_addr_out_reg <= addr_next;
			per_wdata_out_reg <= wdata_next;
		end
	end

	a_guard_locked_hold: assert property (@(posedge mclk) disable iff (!rstn)
		!key_open_reg |=> $stable(peripheral_group_write_guard_reg))
		else $error("guard bits changed while locked");
	a_guard_open_load: assert property (@(posedge mclk) disable iff (!rstn)
		guard_wr && key_open_reg |=> peripheral_group_write_guard_reg == $past(guard_wdata))
		else $error("guard write while open not taken");
	a_locked_write_drop: assert property (@(posedge mclk) disable iff (!rstn)
		per_wr && prlk_is_guarded(peripheral_group_write_guard_reg, per_addr)
		|=> !per_wr_out_reg && per_wr_drop_reg)
		else $error("write to locked group passed");
	a_open_write_pass: assert property (@(posedge mclk) disable iff (!rstn)
		per_wr && !prlk_is_guarded(peripheral_group_write_guard_reg, per_addr)
		|=> per_wr_out_reg && per_addr_out_reg == $past(per_addr) && per_wdata_out_reg == $past(per_wdata))
		else $error("write to unlocked group lost");
	a_read_always_pass: assert property (@(posedge mclk) disable iff (!rstn)
		per_rd |=> per_rd_out_reg && per_addr_out_reg == $past(per_addr))
		else $error("read not passed");
	c_write_dropped: cover property (@(posedge mclk) disable iff (!rstn) per_wr_drop_reg);
	c_guard_loaded: cover property (@(posedge mclk) disable iff (!rstn) guard_wr && key_open_reg);
	c_locked_read: cover property (@(posedge mclk) disable iff (!rstn)
		per_rd && prlk_is_guarded(peripheral_group_write_guard_reg, per_addr));
endmodule

// ### hw/prlk_pkg.sv
// constants for the peripheral register lock block
// assumes one bus clock and a peripheral address whose upper bits pick the group
package prlk_pkg;
	localparam int PRLK_ADDR_W = 12;
	localparam int PRLK_DATA_W = 32;
	localparam int PRLK_KEY_W = 8;
	// groups are selected by address bits [11:8]
	localparam int PRLK_GRP_LSB = 8;
	localparam int PRLK_GRP_W = 4;
	localparam int PRLK_NGRP = 16;
	localparam logic [PRLK_NGRP-1:0] PRLK_GUARD_RST = 16'h0000;
	// key values are arbitrary implementation choices
	localparam logic [PRLK_KEY_W-1:0] PRLK_KEY_FIRST = 8'ha5;
	localparam logic [PRLK_KEY_W-1:0] PRLK_KEY_SECOND = 8'hf1;

	typedef enum logic [2:0] {
		PRLK_LOCKED = 3'h1,
		PRLK_HALF = 3'h2,
		PRLK_OPEN = 3'h4
	} prlk_state_type;

	function automatic logic [PRLK_GRP_W-1:0] prlk_grp_of(input logic [PRLK_ADDR_W-1:0] addr);
		prlk_grp_of = addr[PRLK_GRP_LSB +: PRLK_GRP_W];
	endfunction

	function automatic logic prlk_is_guarded(input logic [PRLK_NGRP-1:0] guard,
		input logic [PRLK_ADDR_W-1:0] addr);
		prlk_is_guarded = guard[prlk_grp_of(addr)];
	endfunction
endpackage

// ### hw/prlk_key_seq.sv
// key sequence tracker: two ordered key writes open the guard bank
// assumes key writes arrive as one-cycle strobes on the bus clock
`timescale 1ns/1ps
module prlk_key_seq import prlk_pkg::*; (
	input wire logic mclk, // bus clock
	input wire logic rstn, // async reset, active low
	input wire logic key_wr, // key register write strobe
	input wire logic [PRLK_KEY_W-1:0] key_wdata, // key write data
	output logic open_reg // guard bank writable
);
	prlk_state_type state_reg;
	prlk_state_type state_next;
	logic open_next;

	always_comb begin
		state_next = state_reg;
		if (key_wr) begin
			case (state_reg)
				PRLK_LOCKED: begin
					// wrong first key leaves the tracker at its start
					state_next = (key_wdata == PRLK_KEY_FIRST) ? PRLK_HALF : PRLK_LOCKED;
				end
				PRLK_HALF: begin
					state_next = (key_wdata == PRLK_KEY_SECOND) ? PRLK_OPEN : PRLK_LOCKED;
				end
				PRLK_OPEN: begin
					// any value relocks, even a valid first key
					state_next = PRLK_LOCKED;
				end
				default: begin
					state_next = PRLK_LOCKED;
				end
			endcase
		end
		open_next = (state_next == PRLK_OPEN);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= PRLK_LOCKED;
			open_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			open_reg <= open_next;
		end
	end

	a_relock_on_key: assert property (@(posedge mclk) disable iff (!rstn)
		(state_reg == PRLK_OPEN) && key_wr |=> !open_reg && (state_reg == PRLK_LOCKED))
		else $error("key write while open did not relock");
	a_bad_key_restart: assert property (@(posedge mclk) disable iff (!rstn)
		(state_reg == PRLK_HALF) && key_wr && (key_wdata != PRLK_KEY_SECOND) |=> state_reg == PRLK_LOCKED)
		else $error("broken key order did not restart tracker");
	a_full_seq_opens: assert property (@(posedge mclk) disable iff (!rstn)
		(state_reg == PRLK_LOCKED) && key_wr && (key_wdata == PRLK_KEY_FIRST)
		##1 key_wr && (key_wdata == PRLK_KEY_SECOND) |=> open_reg)
		else $error("ordered key sequence did not open");
	a_status_tracks_state: assert property (@(posedge mclk) disable iff (!rstn)
		open_reg == (state_reg == PRLK_OPEN))
		else $error("lock status disagrees with tracker");
	c_opened: cover property (@(posedge mclk) disable iff (!rstn) $rose(open_reg));
	c_relocked: cover property (@(posedge mclk) disable iff (!rstn) $fell(open_reg));
endmodule

// ### test/test_peripheral_register_lock.sv
// self-checking bench for the peripheral register lock top level
// assumes prlk_top ports as declared; inputs move 2 ns after each rising edge
`timescale 1ns/1ps
module test_peripheral_register_lock import prlk_pkg::*;;
	logic mclk = 1'b0, rstn = 1'b0, key_wr = 1'b0, guard_wr = 1'b0, per_wr = 1'b0, per_rd = 1'b0;
	logic [PRLK_KEY_W-1:0] key_wdata = 8'h00;
	logic [PRLK_NGRP-1:0] guard_wdata = 16'h0000;
	logic [PRLK_ADDR_W-1:0] per_addr = 12'h000;
	logic [PRLK_DATA_W-1:0] per_wdata = 32'h0000_0000;
	logic key_open_reg, per_wr_out_reg, per_rd_out_reg, per_wr_drop_reg;
	logic [PRLK_NGRP-1:0] guard_q;
	logic [PRLK_ADDR_W-1:0] per_addr_out_reg;
	logic [PRLK_DATA_W-1:0] per_wdata_out_reg;
	int err_total = 0, comparisons = 0;
	prlk_top dut (.mclk(mclk), .rstn(rstn), .key_wr(key_wr), .key_wdata(key_wdata), .guard_wr(guard_wr),
		.guard_wdata(guard_wdata), .per_wr(per_wr), .per_rd(per_rd), .per_addr(per_addr), .per_wdata(per_wdata),
		.key_open_reg(key_open_reg), .peripheral_group_write_guard_reg(guard_q), .per_wr_out_reg(per_wr_out_reg),
		.per_rd_out_reg(per_rd_out_reg), .per_addr_out_reg(per_addr_out_reg),
		.per_wdata_out_reg(per_wdata_out_reg), .per_wr_drop_reg(per_wr_drop_reg));
	initial begin
		forever #10 mclk = ~mclk;
	end
	task automatic tick();
		@(posedge mclk);
		#2;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// an idle edge first, so a strobe is never lowered and raised in one time step
	task automatic key(input logic [PRLK_KEY_W-1:0] v);
		tick();
		key_wr = 1'b1;
		key_wdata = v;
		tick();
		key_wr = 1'b0;
	endtask
	task automatic guard(input logic [PRLK_NGRP-1:0] v);
		tick();
		guard_wr = 1'b1;
		guard_wdata = v;
		tick();
		guard_wr = 1'b0;
	endtask
	task automatic access(input logic wr, input logic rd, input logic [11:0] a, input logic [31:0] d);
		tick();
		per_wr = wr;
		per_rd = rd;
		per_addr = a;
		per_wdata = d;
		tick();
		per_wr = 1'b0;
		per_rd = 1'b0;
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic t_reset_state();
		chk(key_open_reg, 1'b0, "key status after reset");
		chk(guard_q, PRLK_GUARD_RST, "guard bits after reset");
		$display("test reset_state done");
	endtask
	task automatic t_locked_refuse();
		guard(16'hffff);
		chk(guard_q, 16'h0000, "guard write taken while locked");
		$display("test locked_refuse done");
	endtask
	task automatic t_wrong_key();
		key(PRLK_KEY_FIRST);
		key(8'h00);
		chk(key_open_reg, 1'b0, "wrong second key opened");
		key(PRLK_KEY_SECOND);
		chk(key_open_reg, 1'b0, "sequence not restarted");
		guard(16'h00ff);
		chk(guard_q, 16'h0000, "guard changed without full sequence");
		$display("test wrong_key done");
	endtask
	task automatic t_unlock_relock();
		key(PRLK_KEY_FIRST);
		key(PRLK_KEY_SECOND);
		chk(key_open_reg, 1'b1, "ordered keys did not open");
		guard(16'h0004);
		chk(guard_q, 16'h0004, "single guard bit not taken");
		key(8'h5a);
		chk(key_open_reg, 1'b0, "key write while open did not relock");
		guard(16'h0000);
		chk(guard_q, 16'h0004, "guard write taken after relock");
		$display("test unlock_relock done");
	endtask
	task automatic t_write_gate();
		// group 3 open, group 2 locked: only the guarded group is gated
		access(1'b1, 1'b0, 12'h304, 32'hcafe_0001);
		chk({per_wr_out_reg, per_wr_drop_reg}, 2'b10, "open group write gated");
		chk(per_wdata_out_reg, 32'hcafe_0001, "open group data");
		access(1'b1, 1'b0, 12'h210, 32'h1111_2222);
		chk({per_wr_out_reg, per_wr_drop_reg}, 2'b01, "locked write passed");
		chk(per_wdata_out_reg, 32'hcafe_0001, "locked write data leaked");
		access(1'b1, 1'b1, 12'h210, 32'h3333_4444);
		chk({per_rd_out_reg, per_wr_out_reg}, 2'b10, "read with locked write");
		chk(per_addr_out_reg, 12'h210, "read address");
		$display("test write_gate done");
	endtask
	initial begin
		repeat (2000) @(posedge mclk);
		err_total++;
		$display("CHECK FAILED at %0t: run too long", $time);
		complete_run();
	end
	initial begin
		repeat (2) @(posedge mclk);
		#2;
		rstn = 1'b1;
		t_reset_state();
		t_locked_refuse();
		t_wrong_key();
		t_unlock_relock();
		t_write_gate();
		complete_run();
	end
endmodule
